/* File: core/flash_host.sv */
// Purpose: AXI4-Lite driven host that sequences flash commands on pins
// Assumes: flash status is read on dq[7:0]; one operation at a time
// Notes: software writes ADDR, WDATA, then CTRL to start; polls STATUS
`timescale 1ns/1ns
module flash_host
  import flash_host_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output flash_pins_t flash_o,
  input wire logic [DATA_W-1:0] dq_in
);
  typedef struct packed {
    flash_pins_t pins;
    phase_t phase;
    logic [1:0] step;
    logic [7:0] cnt;
    logic [3:0] op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdat;
    logic [DATA_W-1:0] rdat;
    logic [7:0] fstat;
    logic busy;
    logic refused;
    logic err_pend;
    logic susp_prog;
    logic susp_erase;
    logic last_erase;
    logic [ADDR_W-1:0] susp_addr;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [DATA_W-1:0] s1;
    logic [DATA_W-1:0] s2;
    logic [DATA_W-1:0] s3;
    logic awrdy;
    logic wrdy;
    logic arrdy;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  step_t sk;
  logic ctrl_wr;
  logic start_ok;

  // Command list of each operation, indexed by step
  function automatic step_t seq_step(input logic [3:0] op,
                                     input logic [1:0] idx);
    step_t s;
    s = '{kind: STEP_END, cmd: 8'h00, use_data: 1'b0};
    unique case (op)
      OP_PROGRAM: begin
        if (idx == 2'd0) s = '{STEP_WRITE, CMD_PROGRAM, 1'b0};
        if (idx == 2'd1) s = '{STEP_WRITE, 8'h00, 1'b1};
        if (idx == 2'd2) s = '{STEP_POLL, 8'h00, 1'b0};
      end
      OP_ERASE, OP_LOCK_SET, OP_LOCK_CLR: begin
        if (idx == 2'd0) s.kind = STEP_WRITE;
        if (idx == 2'd0) s.cmd = (op == OP_ERASE) ? CMD_ERASE : CMD_LOCK_SETUP;
        if (idx == 2'd1) s.kind = STEP_WRITE;
        if (idx == 2'd1) s.cmd = (op == OP_LOCK_SET) ? CMD_LOCK_SET
                                                     : CMD_CONFIRM;
        if (idx == 2'd2) s.kind = STEP_POLL;
      end
      OP_SUSPEND, OP_RESUME: begin
        if (idx == 2'd0) s.kind = STEP_WRITE;
        if (idx == 2'd0) s.cmd = (op == OP_SUSPEND) ? CMD_SUSPEND
                                                    : CMD_CONFIRM;
        if (idx == 2'd1) s.kind = STEP_POLL;
      end
      OP_READ_ARRAY, OP_CLEAR: begin
        if (idx == 2'd0) s.kind = STEP_WRITE;
        if (idx == 2'd0) s.cmd = (op == OP_CLEAR) ? CMD_CLEAR_STATUS
                                                  : CMD_READ_ARRAY;
      end
      OP_READ: if (idx == 2'd0) s.kind = STEP_READ;
      OP_RESET: if (idx == 2'd0) s.kind = STEP_RP;
      default: s.kind = STEP_END;
    endcase
    return s;
  endfunction : seq_step

  // Byte-lane merge for the ADDR and WDATA registers
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) m[i*8 +: 8] = nw[i*8 +: 8];
    end
    return m;
  endfunction : merge

  // AXI outputs and pins come straight from the state flops
  assign awready = st_r.awrdy;
  assign wready = st_r.wrdy;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign arready = st_r.arrdy;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign flash_o = st_r.pins;
  assign sk = seq_step(st_r.op, st_r.step);
  assign ctrl_wr = st_r.aw_got && st_r.w_got && !st_r.bvalid &&
                   st_r.aw_addr == REG_CTRL && st_r.w_strb[0];

  // Start checks; a refused start leaves the flash untouched
  always_comb begin
    start_ok = !st_r.busy && st_r.w_data[3:0] >= OP_PROGRAM &&
               st_r.w_data[3:0] <= OP_RESET;
    if (st_r.err_pend && st_r.w_data[3:0] != OP_CLEAR &&
        st_r.w_data[3:0] != OP_RESET) start_ok = 1'b0;
    if (st_r.w_data[3:0] == OP_ERASE && st_r.susp_erase) start_ok = 1'b0;
    if (st_r.w_data[3:0] == OP_READ && st_r.susp_prog &&
        st_r.addr == st_r.susp_addr) start_ok = 1'b0;
    if (st_r.w_data[3:0] == OP_PROGRAM && st_r.susp_prog) start_ok = 1'b0;
  end

  // Next state: bus slave, pin sequencer, input synchroniser
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = dq_in;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.w_data = wdata;
      st_nxt.w_strb = wstrb;
    end
    if (st_r.bvalid && bready) st_nxt.bvalid = 1'b0;
    // Register write once address and data are both held
    if (st_r.aw_got && st_r.w_got && !st_r.bvalid) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      unique case (st_r.aw_addr)
        REG_CTRL: ;
        REG_ADDR: if (!st_r.busy) st_nxt.addr = ADDR_W'(merge(
          32'(st_r.addr), st_r.w_data, st_r.w_strb));
        REG_WDATA: if (!st_r.busy) st_nxt.wdat = DATA_W'(merge(
          32'(st_r.wdat), st_r.w_data, st_r.w_strb));
        REG_STATUS: if (st_r.w_strb[0] && st_r.w_data[ST_REFUSED])
          st_nxt.refused = 1'b0;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (arvalid && arready) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      unique case (araddr)
        REG_CTRL: st_nxt.rdata = 32'(st_r.op);
        REG_ADDR: st_nxt.rdata = 32'(st_r.addr);
        REG_WDATA: st_nxt.rdata = 32'(st_r.wdat);
        REG_STATUS: st_nxt.rdata = {16'h0000, st_r.fstat, 3'h0,
          st_r.susp_erase, st_r.susp_prog, st_r.err_pend, st_r.refused,
          st_r.busy};
        REG_RDATA: st_nxt.rdata = 32'(st_r.rdat);
        default: begin
          st_nxt.rdata = 32'h0000_0000;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
    if (ctrl_wr && start_ok) begin
      st_nxt.op = st_r.w_data[3:0];
      st_nxt.step = 2'd0;
      st_nxt.busy = 1'b1;
      st_nxt.phase = PH_FETCH;
      if (st_r.w_data[3:0] == OP_PROGRAM) st_nxt.last_erase = 1'b0;
      if (st_r.w_data[3:0] == OP_PROGRAM) st_nxt.susp_addr = st_r.addr;
      if (st_r.w_data[3:0] == OP_ERASE) st_nxt.last_erase = 1'b1;
    end else if (ctrl_wr) begin
      st_nxt.refused = 1'b1;   // Set wins over a same-cycle clear
    end
    if (st_r.cnt != 8'd0) st_nxt.cnt = st_r.cnt - 8'd1;
    unique case (st_r.phase)
      PH_IDLE: ;
      PH_FETCH: begin
        st_nxt.pins.addr = st_r.addr;
        unique case (sk.kind)
          // setup and confirm at block address
          STEP_WRITE: begin
            st_nxt.pins.dq_out = sk.use_data ? st_r.wdat
                                             : DATA_W'(sk.cmd);
            st_nxt.pins.dq_oe = 1'b1;
            st_nxt.pins.ce_n = 1'b0;
            st_nxt.pins.we_n = 1'b0;
            st_nxt.cnt = WP_CYC - 8'd1;
            st_nxt.phase = PH_WE;
          end
          STEP_POLL, STEP_READ: begin
            st_nxt.pins.ce_n = 1'b0;
            st_nxt.pins.oe_n = 1'b0;
            st_nxt.cnt = ACC_CYC - 8'd1;
            st_nxt.phase = PH_OE;
          end
          // pulse pin low, drop status copy
          STEP_RP: begin
            st_nxt.pins.reset_powerdown_low = 1'b0;
            st_nxt.cnt = RP_CYC - 8'd1;
            st_nxt.phase = PH_RP;
            st_nxt.fstat = 8'h00;
            st_nxt.err_pend = 1'b0;
            st_nxt.susp_prog = 1'b0;
            st_nxt.susp_erase = 1'b0;
          end
          STEP_END: begin
            st_nxt.busy = 1'b0;
            st_nxt.phase = PH_IDLE;
            if (st_r.op == OP_SUSPEND &&
                st_r.fstat[SUSPENDED_FLAG]) begin
              st_nxt.susp_prog = !st_r.last_erase;
              st_nxt.susp_erase = st_r.last_erase;
            end
            if (st_r.op == OP_RESUME) begin
              st_nxt.susp_prog = 1'b0;
              st_nxt.susp_erase = 1'b0;
            end
            if (st_r.op == OP_CLEAR) begin
              st_nxt.err_pend = 1'b0;
              st_nxt.fstat = 8'h00;
            end
          end
          default: st_nxt.phase = PH_IDLE;
        endcase
      end
      PH_WE: if (st_r.cnt == 8'd0) begin
        st_nxt.pins.we_n = 1'b1;
        st_nxt.pins.ce_n = 1'b1;
        st_nxt.step = st_r.step + 2'd1;
        st_nxt.cnt = GAP_CYC;
        st_nxt.phase = PH_GAP;
      end
      PH_OE: if (st_r.cnt == 8'd0) st_nxt.phase = PH_SAMPLE;
      // Wait for the second and third sync stages to agree
      PH_SAMPLE: if (st_r.s2 == st_r.s3) begin
        // raise OE so next poll refreshes status
        st_nxt.pins.oe_n = 1'b1;
        st_nxt.pins.ce_n = 1'b1;
        st_nxt.cnt = GAP_CYC;
        st_nxt.phase = PH_GAP;
        if (sk.kind == STEP_READ) begin
          st_nxt.rdat = st_r.s3;
          st_nxt.step = st_r.step + 2'd1;
        end else if (st_r.s3[ENGINE_READY_FLAG]) begin
          // error flags read only once ready
          st_nxt.fstat = st_r.s3[7:0];
          st_nxt.step = st_r.step + 2'd1;
          if (st_r.s3[ERASE_CLEAR_ERROR_FLAG] ||
              st_r.s3[PROGRAM_SET_ERROR_FLAG] ||
              st_r.s3[SUPPLY_VOLTAGE_ERROR_FLAG] ||
              st_r.s3[PROTECT_ERROR_FLAG]) st_nxt.err_pend = 1'b1;
        end
      end
      PH_GAP: if (st_r.cnt == 8'd0) begin
        st_nxt.pins.dq_oe = 1'b0;   // Data held past WE rise
        st_nxt.phase = PH_FETCH;
      end
      PH_RP: if (st_r.cnt == 8'd0) begin
        st_nxt.pins.reset_powerdown_low = 1'b1;
        st_nxt.step = st_r.step + 2'd1;
        st_nxt.cnt = RP_CYC;   // Recovery before next access
        st_nxt.phase = PH_GAP;
      end
      default: st_nxt.phase = PH_IDLE;
    endcase
    // Readies registered so every output leaves a flop
    st_nxt.awrdy = !st_nxt.aw_got && !st_nxt.bvalid;
    st_nxt.wrdy = !st_nxt.w_got && !st_nxt.bvalid;
    st_nxt.arrdy = !st_nxt.rvalid;
  end

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.phase <= PH_IDLE;
      st_r.pins.ce_n <= 1'b1;
      st_r.pins.oe_n <= 1'b1;
      st_r.pins.we_n <= 1'b1;
      st_r.pins.reset_powerdown_low <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  AST_PROG_SETUP: assert property (
    st_r.phase == PH_WE && st_r.op == OP_PROGRAM && st_r.step == 2'd0
    |-> st_r.pins.dq_out == DATA_W'(CMD_PROGRAM) && !st_r.pins.we_n)
    else $error("program setup code wrong");
  AST_READ_ARRAY: assert property (
    st_r.phase == PH_WE && st_r.op == OP_READ_ARRAY
    |-> st_r.pins.dq_out == DATA_W'(CMD_READ_ARRAY))
    else $error("read array code wrong");
  AST_ERR_HOLD: assert property (
    ctrl_wr && st_r.err_pend && st_r.w_data[3:0] == OP_PROGRAM
    |=> st_r.refused && !st_r.busy ##0 !st_r.pins.dq_oe[*2])
    else $error("start taken with error pending");
  AST_SUSPEND_FLAG: assert property (
    st_r.phase == PH_FETCH && sk.kind == STEP_END &&
    st_r.op == OP_SUSPEND && st_r.fstat[SUSPENDED_FLAG]
    |=> (st_r.susp_prog || st_r.susp_erase) && !st_r.busy)
    else $error("suspension not recorded");
  AST_SUSP_READ: assert property (
    ctrl_wr && st_r.w_data[3:0] == OP_READ && st_r.susp_prog &&
    st_r.addr == st_r.susp_addr && !st_r.busy |=> st_r.refused)
    else $error("read of suspended location allowed");
  AST_ERASE_CONFIRM: assert property (
    st_r.phase == PH_WE && st_r.op == OP_ERASE && st_r.step == 2'd1
    |-> st_r.pins.dq_out == DATA_W'(CMD_CONFIRM) &&
        st_r.pins.addr == st_r.addr)
    else $error("erase confirm wrong");
  AST_ONE_ERASE: assert property (
    ctrl_wr && st_r.w_data[3:0] == OP_ERASE && st_r.susp_erase
    |=> st_r.refused)
    else $error("second erase taken");
  AST_RESUME: assert property (
    st_r.phase == PH_WE && st_r.op == OP_RESUME
    |-> st_r.pins.dq_out == DATA_W'(CMD_CONFIRM))
    else $error("resume code wrong");
  AST_LOCK_SET: assert property (
    st_r.phase == PH_WE && st_r.op == OP_LOCK_SET && st_r.step == 2'd1
    |-> st_r.pins.dq_out == DATA_W'(CMD_LOCK_SET))
    else $error("lock set confirm wrong");
  AST_LOCK_CLR: assert property (
    st_r.phase == PH_WE && st_r.op == OP_LOCK_CLR && st_r.step == 2'd1
    |-> st_r.pins.dq_out == DATA_W'(CMD_CONFIRM))
    else $error("lock clear confirm wrong");
  AST_READY_FIRST: assert property (
    $rose(st_r.err_pend) |-> st_r.fstat[ENGINE_READY_FLAG])
    else $error("error taken before ready");
  COV_PROGRAM: cover property (st_r.op == OP_PROGRAM && $fell(st_r.busy));
  COV_SUSPEND: cover property ($rose(st_r.susp_erase));
  COV_REFUSED: cover property ($rose(st_r.refused));
  COV_ERROR: cover property ($rose(st_r.err_pend));
endmodule : flash_host

/* File: core/flash_host_pkg.sv */
// Purpose: constants and types for the parallel flash command controller
// Assumes: 50 MHz aclk, 16-bit flash data bus, status in the low byte
// Notes: opcodes and offsets are the software view of the controller
package flash_host_pkg;
  localparam int ADDR_W = 23;
  localparam int DATA_W = 16;
  // Flash command codes
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
  localparam logic [7:0] CMD_LOCK_SET = 8'h01;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // Flash status bit positions
  localparam int ENGINE_READY_FLAG = 7;
  localparam int SUSPENDED_FLAG = 6;
  localparam int ERASE_CLEAR_ERROR_FLAG = 5;
  localparam int PROGRAM_SET_ERROR_FLAG = 4;
  localparam int SUPPLY_VOLTAGE_ERROR_FLAG = 3;
  localparam int PROTECT_ERROR_FLAG = 1;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  // Status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_REFUSED = 1;
  localparam int ST_ERR_PEND = 2;
  localparam int ST_SUSP_PROG = 3;
  localparam int ST_SUSP_ERASE = 4;
  localparam int ST_FLASH_LSB = 8;
  // Operation codes written to CTRL[3:0]
  localparam logic [3:0] OP_PROGRAM = 4'h1;
  localparam logic [3:0] OP_ERASE = 4'h2;
  localparam logic [3:0] OP_LOCK_SET = 4'h3;
  localparam logic [3:0] OP_LOCK_CLR = 4'h4;
  localparam logic [3:0] OP_SUSPEND = 4'h5;
  localparam logic [3:0] OP_RESUME = 4'h6;
  localparam logic [3:0] OP_READ_ARRAY = 4'h7;
  localparam logic [3:0] OP_CLEAR = 4'h8;
  localparam logic [3:0] OP_READ = 4'h9;
  localparam logic [3:0] OP_RESET = 4'ha;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // Timing, least times rounded up to cycles
  localparam int CLK_NS = 20;
  localparam int T_WP_NS = 70;
  localparam int T_ACC_NS = 150;
  localparam int T_GAP_NS = 40;
  localparam int T_RP_NS = 1000;
  localparam logic [7:0] WP_CYC = 8'((T_WP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] ACC_CYC = 8'((T_ACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] GAP_CYC = 8'((T_GAP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] RP_CYC = 8'((T_RP_NS + CLK_NS - 1) / CLK_NS);

  typedef enum logic [2:0] {STEP_WRITE, STEP_POLL, STEP_READ, STEP_RP,
    STEP_END} step_kind_t;
  typedef struct packed {
    step_kind_t kind;
    logic [7:0] cmd;
    logic use_data;
  } step_t;
  typedef enum logic [2:0] {PH_IDLE, PH_FETCH, PH_WE, PH_OE, PH_SAMPLE,
    PH_GAP, PH_RP} phase_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_out;
    logic dq_oe;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic reset_powerdown_low;
  } flash_pins_t;
endpackage : flash_host_pkg

/* File: dv/flash_dev_model.sv */
// Purpose: behavioural parallel flash answering the host's pin cycles
// Assumes: commands on dq[7:0]; block number is addr[22:16]
// Notes: busy lasts BUSY_POLLS status reads; dq has no pull
`timescale 1ns/1ns
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter int BUSY_POLLS = 3
)(
  input wire flash_pins_t pins,
  input wire logic vpen_low,
  output logic [DATA_W-1:0] dq_in
);
  logic [DATA_W-1:0] mem [bit [22:0]];
  logic [127:0] lock_r = '0;
  logic [6:0] sr = '0;
  logic [7:0] pend = '0;
  logic arr = 1'b1;
  int busy = 0;
  logic [22:0] wa = '0;
  logic [15:0] wd = '0;
  initial dq_in = '0;
  // Latch address and data while the strobe is low
  always @(pins) begin
    if (!pins.we_n && !pins.ce_n) begin
      wa = pins.addr;
      wd = pins.dq_out;
    end
  end
  always @(posedge pins.we_n) begin
    bit [22:0] q[$];
    if (pins.reset_powerdown_low && (busy == 0 || wd[7:0] == CMD_SUSPEND)) begin
      if (pend == CMD_PROGRAM) begin
        if (vpen_low) sr[4:3] = 2'b11;
        else if (lock_r[wa[22:16]]) sr[4] = 1'b1;
        if (!vpen_low && lock_r[wa[22:16]]) sr[1] = 1'b1;
        if (!vpen_low && !lock_r[wa[22:16]]) mem[wa] = wd;
        busy = BUSY_POLLS;
      end else if (pend == CMD_ERASE) begin
        foreach (mem[k]) if (k[22:16] == wa[22:16]) q.push_back(k);
        if (wd[7:0] == CMD_CONFIRM) foreach (q[i]) mem.delete(q[i]);
        else sr[5:4] = 2'b11;
        busy = BUSY_POLLS;
      end else if (pend == CMD_LOCK_SETUP) begin
        if (wd[7:0] == CMD_LOCK_SET) lock_r[wa[22:16]] = 1'b1;
        else if (wd[7:0] == CMD_CONFIRM) lock_r = '0;
        else sr[5:4] = 2'b11;
        busy = BUSY_POLLS;
      end else begin
        case (wd[7:0])
          CMD_SUSPEND: begin
            sr[6] = busy != 0;
            busy = 0;
            arr = 1'b0;
          end
          CMD_CONFIRM: begin
            if (sr[6]) busy = BUSY_POLLS;
            sr[6] = 1'b0;
          end
          CMD_READ_ARRAY: arr = 1'b1;
          CMD_CLEAR_STATUS: sr[5:0] = '0;
          default: arr = 1'b0;
        endcase
      end
      pend = (pend == 8'h00 && wd[7:0] inside {CMD_PROGRAM, CMD_ERASE,
        CMD_LOCK_SETUP}) ? wd[7:0] : 8'h00;
    end
  end
  always @(negedge pins.oe_n) begin
    if (arr) dq_in = mem.exists(pins.addr) ? mem[pins.addr] : '1;
    else dq_in = {8'h00, busy == 0, sr};
    if (!arr && busy > 0) busy--;
  end
  // Released bus shows the inverse, never a held copy
  always @(posedge pins.oe_n) dq_in = ~dq_in;
  always @(negedge pins.reset_powerdown_low) begin
    sr = '0;
    busy = 0;
    pend = 8'h00;
    arr = 1'b1;
  end
endmodule : flash_dev_model

/* File: dv/flash_host_tb_top.sv */
// Purpose: self-checking bench for the AXI4-Lite flash command host
// Assumes: behavioural flash model on the pins, 50 MHz clock
// Notes: rows run in order and lean on the state left by earlier rows
`timescale 1ns/1ns
module flash_host_tb_top
  import flash_host_pkg::*;
;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = '0;
  logic [7:0] araddr = '0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic vpen_low = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  flash_pins_t flash_o;
  logic [DATA_W-1:0] dq_in;
  int fail_count = 0;
  int n_compared = 0;
  typedef struct {
    logic [3:0] op; logic [22:0] a; logic [15:0] d; logic vp;
    logic [15:0] m; logic [15:0] st; logic [15:0] rd;
  } row_t;
  // Ordinary cases: op, addr, data, low supply, mask, status, read data
  row_t rows [20] = '{
    '{OP_PROGRAM, 23'h10, 16'h1234, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_PROGRAM, 23'h10008, 16'h0f0f, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_ERASE, 23'h10000, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_LOCK_SET, 23'h20000, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_PROGRAM, 23'h20004, 16'habcd, 1'b0, 16'hffff, 16'h9204, 16'h0},
    '{OP_PROGRAM, 23'h20, 16'h1111, 1'b0, 16'hffff, 16'h9206, 16'h0},
    '{OP_CLEAR, 23'h0, 16'h0, 1'b0, 16'h00ff, 16'h0000, 16'h0},
    '{OP_LOCK_CLR, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_PROGRAM, 23'h20004, 16'habcd, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_SUSPEND, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_RESUME, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_PROGRAM, 23'h30, 16'h5555, 1'b1, 16'hffff, 16'h9804, 16'h0},
    '{OP_RESET, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h0000, 16'h0},
    '{OP_PROGRAM, 23'h30, 16'h5555, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_READ_ARRAY, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h0},
    '{OP_READ, 23'h10, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h1234},
    '{OP_READ, 23'h30, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'h5555},
    '{OP_READ, 23'h10008, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'hffff},
    '{OP_READ, 23'h20004, 16'h0, 1'b0, 16'hffff, 16'h8000, 16'habcd},
    '{4'hf, 23'h0, 16'h0, 1'b0, 16'hffff, 16'h8002, 16'h0}};

  flash_host i_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .flash_o(flash_o), .dq_in(dq_in));
  flash_dev_model i_flash (.pins(flash_o), .vpen_low(vpen_low),
    .dq_in(dq_in));

  // Free-running 50 MHz clock
  always #10 aclk = ~aclk;

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : results

  task automatic hang();
    fail_count++;
    results();
  endtask : hang

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", nm, e, g);
      fail_count++;
    end
  endtask : chk

  // Write: address and data offered together, each dropped when taken
  task automatic axw(input logic [7:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
      n++;
      if (n > 200) hang();
    end
    r = bresp;
    bready <= 1'b0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
      n++;
      if (n > 200) hang();
    end
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : axr

  // Poll busy; the limit stands in for a hung flash sequence
  task automatic wait_idle(output logic [31:0] st);
    logic [1:0] r;
    int n = 0;
    do begin
      axr(REG_STATUS, st, r);
      n++;
      if (n > 3000) hang();
    end while (st[ST_BUSY] !== 1'b0);
  endtask : wait_idle

  task automatic run_op(input row_t w, output logic [31:0] st);
    logic [1:0] r;
    axw(REG_STATUS, 32'h2, r);
    axw(REG_ADDR, {9'h0, w.a}, r);
    axw(REG_WDATA, {16'h0, w.d}, r);
    axw(REG_CTRL, {28'h0, w.op}, r);
    wait_idle(st);
  endtask : run_op

  initial begin
    logic [31:0] st, v;
    logic [1:0] r;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      vpen_low <= rows[i].vp;
      run_op(rows[i], st);
      chk("status", {16'h0, rows[i].st & rows[i].m}, st & {16'h0, rows[i].m}); // row
      if (rows[i].op == OP_READ) begin
        axr(REG_RDATA, v, r);
        chk("rdata", {16'h0, rows[i].rd}, v); // array
      end
    end
    // Second reset in mid-run: pins idle, registers cleared
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (5) @(posedge aclk);
    chk("pins idle", 32'h3, {30'h0, flash_o.ce_n, flash_o.reset_powerdown_low}); // idle
    aresetn <= 1'b1;
    axr(REG_STATUS, v, r);
    chk("status reset", 32'h0, v); // cleared
    axr(8'h20, v, r);
    chk("unmapped read", {28'h0, RESP_SLVERR, 2'h0}, {28'h0, r, 2'h0});
    chk("unmapped data", 32'h0, v);
    axw(8'h20, 32'h1, r);
    chk("unmapped write", {30'h0, RESP_SLVERR}, {30'h0, r});
    // Back-to-back start: second order while busy must be refused
    axw(REG_ADDR, 32'h40, r);
    axw(REG_CTRL, {28'h0, OP_PROGRAM}, r);
    axw(REG_CTRL, {28'h0, OP_ERASE}, r);
    wait_idle(st);
    chk("busy refusal", 32'h8002, st); // refused
    results();
  end
endmodule : flash_host_tb_top
